// ==== logic/ratio_load_pkg.sv ====
// Notes on behaviour
// - swallow latch stores, copies low bits forward
// - swallow update keeps first buffer unchanged
// - swallow update keeps configuration unchanged
// - reference write applies top bits at once
// - reference write fills first buffer only
// - extra strobe copies first to second buffer unless a load pulse lands with it
// - counter finishes present cycle before new ratio
package ratio_load_pkg;
    localparam int REF_WIDTH = 16;
    localparam int REF_LOW_WIDTH = 13;
    localparam int REF_TOP_LSB = 13;
    localparam int SWALLOW_WIDTH = 6;
    localparam int MAIN_WIDTH = 12;
    localparam int CONFIG_WIDTH = 8;
    localparam int PRESCALE_MODULUS = 64;
    localparam logic [15:0] REF_RESET = 16'h0000;
    localparam logic [12:0] REF_LOW_RESET = 13'h0001;
    localparam logic [5:0] SWALLOW_RESET = 6'h00;
    localparam logic [11:0] MAIN_RESET = 12'h000;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
endpackage

// ==== logic/ref_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module ref_counter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [12:0] ratio,
    output logic compareTick
);
    logic [12:0] count;
    logic [12:0] next_count;
    logic next_tick;
    always_comb begin
        next_count = count - 13'h0001;
        next_tick = 1'b0;
        if (count <= 13'h0001) begin
            next_count = ratio;
            next_tick = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= ratio_load_pkg::REF_LOW_RESET;
            compareTick <= 1'b0;
        end else if (clkEn) begin
            count <= next_count;
            compareTick <= next_tick;
        end
    end
    count_steps_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && count > 13'h0001 |=> count == $past(count) - 13'h0001)
        else $error("reference count jumped mid cycle");
endmodule
`default_nettype wire

// ==== logic/divider_ratio_load_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module divider_ratio_load_control (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic refLoad,
    input wire logic swallowLoad,
    input wire logic mainLoad,
    input wire logic configLoad,
    input wire logic latch_strobe_n,
    input wire logic [15:0] loadData,
    output logic [2:0] refSelect,
    output logic [12:0] refFirstBuf,
    output logic [12:0] refRatio,
    output logic [5:0] swallowRatio,
    output logic [11:0] mainRatio,
    output logic [7:0] configBits,
    output logic phaseCompareTick
);
    logic strobePrev;
    logic strobeRise;
    logic [2:0] next_refSelect;
    logic [12:0] next_refFirstBuf;
    logic [12:0] next_refRatio;
    logic [5:0] next_swallowRatio;
    logic [11:0] next_mainRatio;
    logic [7:0] next_configBits;

    // any load pulse this cycle; a strobe edge then counts for nothing
    function automatic logic anyLoad(
        input logic r,
        input logic s,
        input logic m,
        input logic c
    );
        return r || s || m || c;
    endfunction

    // strobe completes on its rising edge, like a latch pulse
    assign strobeRise = latch_strobe_n && !strobePrev;

    always_comb begin
        next_refSelect = refSelect;
        next_refFirstBuf = refFirstBuf;
        next_refRatio = refRatio;
        next_swallowRatio = swallowRatio;
        next_mainRatio = mainRatio;
        next_configBits = configBits;
        if (refLoad) begin
            next_refSelect = loadData[15:13];
            // low bits wait in first buffer
            next_refFirstBuf = loadData[12:0];
        end
        if (swallowLoad) begin
            next_swallowRatio = loadData[5:0];
            next_refRatio = refFirstBuf;
        end
        if (strobeRise && !anyLoad(refLoad, swallowLoad, mainLoad, configLoad)) begin
            next_refRatio = refFirstBuf;
        end
        if (mainLoad) begin
            next_mainRatio = loadData[11:0];
        end
        if (configLoad) begin
            next_configBits = loadData[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strobePrev <= 1'b1;
            refSelect <= ratio_load_pkg::REF_RESET[15:13];
            refFirstBuf <= ratio_load_pkg::REF_LOW_RESET;
            refRatio <= ratio_load_pkg::REF_LOW_RESET;
            swallowRatio <= ratio_load_pkg::SWALLOW_RESET;
            mainRatio <= ratio_load_pkg::MAIN_RESET;
            configBits <= ratio_load_pkg::CONFIG_RESET;
        end else if (clkEn) begin
            strobePrev <= latch_strobe_n;
            refSelect <= next_refSelect;
            refFirstBuf <= next_refFirstBuf;
            refRatio <= next_refRatio;
            swallowRatio <= next_swallowRatio;
            mainRatio <= next_mainRatio;
            configBits <= next_configBits;
        end
    end

    ref_counter refCount (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .ratio(refRatio),
        .compareTick(phaseCompareTick)
    );

    swallow_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && swallowLoad && !refLoad |=> refRatio == $past(refFirstBuf))
        else $error("swallow load did not copy first buffer");
    swallow_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && swallowLoad && !refLoad |=> $stable(refFirstBuf))
        else $error("swallow load changed first buffer");
    swallow_config_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && swallowLoad && !configLoad |=> $stable(configBits))
        else $error("swallow load changed configuration");
    ref_top_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && refLoad |=> refSelect == $past(loadData[15:13]))
        else $error("top reference bits not applied");
    ref_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && refLoad && !swallowLoad |=> $stable(refRatio) && $stable(swallowRatio))
        else $error("reference write changed active ratio");
    strobe_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && strobeRise && !anyLoad(refLoad, swallowLoad, mainLoad, configLoad)
        |=> refRatio == $past(refFirstBuf) && $stable(configBits))
        else $error("strobe did not copy first buffer");
    strobe_keeps_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && strobeRise && !anyLoad(refLoad, swallowLoad, mainLoad, configLoad)
        |=> $stable(refFirstBuf) && $stable(swallowRatio))
        else $error("strobe changed first buffer or swallow value");
    // a strobe edge that meets a load is dropped, not deferred
    strobe_refused_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && strobeRise && !swallowLoad && (refLoad || mainLoad || configLoad)
        |=> $stable(refRatio))
        else $error("strobe copied while a load was pending");
    ref_swallow_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && refLoad && swallowLoad |=> refRatio == $past(refFirstBuf))
        else $error("joint load did not forward old first buffer");
    main_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && mainLoad |=> mainRatio == $past(loadData[11:0]))
        else $error("main ratio not stored");
    config_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && configLoad |=> configBits == $past(loadData[7:0]))
        else $error("configuration not stored");
    // enable low must freeze every stored ratio
    freeze_ratio_a: assert property (@(posedge clk_sys) disable iff (rst)
        !clkEn |=> $stable(refRatio) && $stable(refFirstBuf) && $stable(swallowRatio))
        else $error("ratio moved while enable low");
    freeze_misc_a: assert property (@(posedge clk_sys) disable iff (rst)
        !clkEn |=> $stable(refSelect) && $stable(mainRatio) && $stable(configBits))
        else $error("register moved while enable low");
    freeze_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
        !clkEn |=> $stable(phaseCompareTick))
        else $error("compare tick moved while enable low");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output logic refLoad,
    output logic swallowLoad,
    output logic mainLoad,
    output logic configLoad,
    output logic latch_strobe_n,
    output logic [15:0] loadData
);
    initial begin
        {refLoad, swallowLoad, mainLoad, configLoad} = 4'h0;
        latch_strobe_n = 1'b1;
        loadData = 16'h0000;
    end
    task automatic pulse(input int sel, input logic [15:0] d);
        @(posedge clk_sys);
        loadData <= d;
        refLoad <= (sel == 0);
        swallowLoad <= (sel == 1);
        mainLoad <= (sel == 2);
        configLoad <= (sel == 3);
        @(posedge clk_sys);
        {refLoad, swallowLoad, mainLoad, configLoad} <= 4'h0;
        // released data no longer holds its value
        loadData <= ~d;
    endtask
    // strobe edge lands with a main load, so it must be ignored
    task automatic strobe_with_load(input logic [15:0] d);
        @(posedge clk_sys);
        latch_strobe_n <= 1'b0;
        @(posedge clk_sys);
        latch_strobe_n <= 1'b1;
        mainLoad <= 1'b1;
        loadData <= d;
        @(posedge clk_sys);
        mainLoad <= 1'b0;
        loadData <= ~d;
    endtask
    task automatic strobe();
        @(posedge clk_sys);
        latch_strobe_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        latch_strobe_n <= 1'b1;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) check_count++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, a); end
module tb;
    logic clk_sys, rst, clkEn, refLoad, swallowLoad, mainLoad, configLoad, latch_strobe_n;
    logic phaseCompareTick;
    logic [15:0] loadData;
    logic [2:0] refSelect;
    logic [12:0] refFirstBuf, refRatio;
    logic [5:0] swallowRatio;
    logic [11:0] mainRatio;
    logic [7:0] configBits;
    int err_total = 0;
    int check_count = 0;
    divider_ratio_load_control u_divider_ratio_load_control (.clk_sys(clk_sys), .rst(rst),
        .clkEn(clkEn), .refLoad(refLoad), .swallowLoad(swallowLoad), .mainLoad(mainLoad),
        .configLoad(configLoad), .latch_strobe_n(latch_strobe_n), .loadData(loadData),
        .refSelect(refSelect), .refFirstBuf(refFirstBuf), .refRatio(refRatio),
        .swallowRatio(swallowRatio), .mainRatio(mainRatio), .configBits(configBits),
        .phaseCompareTick(phaseCompareTick));
    host_model u_host_model (.clk_sys(clk_sys), .refLoad(refLoad), .swallowLoad(swallowLoad),
        .mainLoad(mainLoad), .configLoad(configLoad), .latch_strobe_n(latch_strobe_n),
        .loadData(loadData));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic ref_write();
        u_host_model.pulse(0, 16'h2005);
        #1;
        `CHK("refSelect", 3'h1, refSelect)
        `CHK("refFirstBuf", 13'h0005, refFirstBuf)
        `CHK("refRatio", 13'h0001, refRatio)
    endtask
    task automatic swallow_load();
        u_host_model.pulse(3, 16'h00a5);
        u_host_model.pulse(1, 16'h0003);
        #1;
        `CHK("swallowRatio", 6'h03, swallowRatio)
        `CHK("refRatio", 13'h0005, refRatio)
        `CHK("refFirstBuf", 13'h0005, refFirstBuf)
        `CHK("configBits", 8'ha5, configBits)
    endtask
    task automatic extra_strobe();
        u_host_model.pulse(2, 16'h0123);
        u_host_model.pulse(0, 16'h0007);
        u_host_model.strobe();
        #1;
        `CHK("refRatio", 13'h0007, refRatio)
        `CHK("refFirstBuf", 13'h0007, refFirstBuf)
        `CHK("swallowRatio", 6'h03, swallowRatio)
        `CHK("configBits", 8'ha5, configBits)
        `CHK("mainRatio", 12'h123, mainRatio)
    endtask
    task automatic freeze_hold();
        @(posedge clk_sys);
        clkEn <= 1'b0;
        u_host_model.pulse(1, 16'h0011);
        clkEn <= 1'b1;
        #1;
        `CHK("frozen swallowRatio", 6'h03, swallowRatio)
        `CHK("frozen refRatio", 13'h0007, refRatio)
    endtask
    task automatic strobe_refused();
        u_host_model.pulse(0, 16'h0009);
        u_host_model.strobe_with_load(16'h0456);
        #1;
        `CHK("refused refRatio", 13'h0007, refRatio)
        `CHK("refused refFirstBuf", 13'h0009, refFirstBuf)
        `CHK("refused mainRatio", 12'h456, mainRatio)
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (phaseCompareTick !== 1'b1 && n < 40);
        if (phaseCompareTick !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic tick_spacing();
        int n;
        wait_tick(n);
        wait_tick(n);
        `CHK("tick period", 7, n)
    endtask
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        ref_write();
        swallow_load();
        extra_strobe();
        freeze_hold();
        strobe_refused();
        tick_spacing();
        report_and_stop();
    end
endmodule
`default_nettype wire
